/* emb_pkg.sv */
package emb_pkg;

  // ==========================================================
  // storage geometry
  localparam int MEM_BITS = 2048;
  localparam int ROW_W = 8;
  localparam int ROWS = 256;
  localparam int ADDR_W = 11;
  localparam int PTR_W = 12;
  localparam int PADDR_W = 8;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DIV = 8'h04;
  localparam logic [7:0] OFS_LDADDR = 8'h08;
  localparam logic [7:0] OFS_LDDATA = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // ==========================================================
  // field positions and reset values
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SHAPE_LSB = 2;
  localparam int CTRL_INREG_BIT = 4;
  localparam int CTRL_OUTREG_BIT = 5;
  localparam int CTRL_AWREG_BIT = 6;
  localparam int CTRL_RUN_BIT = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int DIV_OUT_LSB = 8;
  localparam logic [15:0] DIV_RST = 16'h0000;
  localparam logic [7:0] LDADDR_RST = 8'h00;
  localparam int STAT_FULL_BIT = 12;
  localparam int STAT_EMPTY_BIT = 13;

  // ==========================================================
  // modes and shapes
  typedef enum logic [1:0] {
    EMB_RAM = 2'b00,
    EMB_ROM = 2'b01,
    EMB_DPRAM = 2'b10,
    EMB_FIFO = 2'b11
  } emb_mode_e;

  typedef enum logic [1:0] {
    EMB_256X8 = 2'b00,
    EMB_512X4 = 2'b01,
    EMB_1024X2 = 2'b10,
    EMB_2048X1 = 2'b11
  } emb_shape_e;

endpackage

/* emb_mem_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface emb_mem_if;
  logic wr_en;
  logic [7:0] wr_row;
  logic [7:0] wr_mask;
  logic [7:0] wr_bits;
  logic [7:0] rd_row_addr;
  logic [7:0] rd_row;
  modport ctrl(output wr_en, output wr_row, output wr_mask, output wr_bits,
               output rd_row_addr, input rd_row);
  modport mem(input wr_en, input wr_row, input wr_mask, input wr_bits,
              input rd_row_addr, output rd_row);
endinterface
`default_nettype wire

/* emb_array.sv */
`timescale 1ns/100ps
`default_nettype none
module emb_array (
  // clock
  input wire logic pclk,
  // row port
  emb_mem_if.mem mp
);

  // ==========================================================
  // storage
  logic [emb_pkg::ROW_W-1:0] mem [emb_pkg::ROWS];
  logic [emb_pkg::ROW_W-1:0] row_next;
  logic [emb_pkg::ROW_W-1:0] rd_next;

  if (emb_pkg::ROWS * emb_pkg::ROW_W != emb_pkg::MEM_BITS) begin : g_chk
    $error("row geometry does not give the full capacity");
  end

  // masked write keeps the other lanes of the row
  always_comb begin
    row_next = (mem[mp.wr_row] & ~mp.wr_mask) | (mp.wr_bits & mp.wr_mask);
    rd_next = mem[mp.rd_row_addr];
  end

  always_ff @(posedge pclk) begin
    if (mp.wr_en) begin
      mem[mp.wr_row] <= row_next;
    end
    mp.rd_row <= rd_next;
  end

endmodule
`default_nettype wire

/* emb_cen_div.sv */
`timescale 1ns/100ps
`default_nettype none
module emb_cen_div #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // divide ratio: enable every div+1 cycles
  input wire logic [W-1:0] div,
  output logic ce
);

  // ==========================================================
  // counter
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic ce_reg;
  logic ce_next;

  if (W < 1 || W > 8) begin : g_chk
    $error("divider width must be 1 to 8");
  end

  always_comb begin
    if (cnt_reg >= div) begin
      cnt_next = '0;
      ce_next = 1'b1;
    end else begin
      cnt_next = W'(cnt_reg + 1'b1);
      ce_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      ce_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      ce_reg <= ce_next;
    end
  end

  assign ce = ce_reg;

endmodule
`default_nettype wire

/* emb_embedded_memory_block.sv */
// Operation
// RULE_01: block stores exactly 2,048 bits, all usable in every shape.
// RULE_02: block acts as RAM, ROM, dual-port RAM or FIFO, chosen by setup.
// RULE_03: RAM shape is 256x8, 512x4, 1,024x2 or 2,048x1.
// RULE_04: lookup use preloads a fixed pattern and returns it per input value.
// RULE_05: block makes its own write pulse from its clock timing.
// RULE_06: input side and output side run on separate clock rates.
// RULE_07: data-in, data-out and address/write registers each present or bypassed.
// RULE_08: user logic drives the write request from global or local routing.
// RULE_09: user logic supplies the clocks from global, pin or local routing.
// RULE_10: parallel blocks on a shared address make wider memories.
// RULE_11: cascaded blocks selected by upper address bits make deeper memories.
// RULE_12: address width follows depth, 8 to 11 bits; data width follows word.
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module emb_embedded_memory_block #(
  parameter int DIV_W = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [emb_pkg::PADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // user input side
  input wire logic [emb_pkg::ADDR_W-1:0] usr_addr,
  input wire logic [emb_pkg::ROW_W-1:0] usr_din,
  input wire logic usr_we,
  input wire logic usr_blk_sel,
  // user output side
  input wire logic [emb_pkg::ADDR_W-1:0] usr_raddr,
  input wire logic usr_re,
  output logic [emb_pkg::ROW_W-1:0] usr_dout,
  output logic usr_full,
  output logic usr_empty
);

  if (DIV_W < 1 || DIV_W > emb_pkg::DIV_OUT_LSB) begin : g_chk
    $error("DIV_W must be 1 to 8");
  end

  // ==========================================================
  // shape helpers
  // only the low 8+shape address bits count, so wider inputs are ignored
  function automatic logic [7:0] row_of(input logic [10:0] a, input logic [1:0] s);
    logic [7:0] r;
    r = a[7:0];
    unique case (s)
      emb_pkg::EMB_256X8: r = a[7:0];
      emb_pkg::EMB_512X4: r = a[8:1];
      emb_pkg::EMB_1024X2: r = a[9:2];
      emb_pkg::EMB_2048X1: r = a[10:3];
    endcase
    return r;
  endfunction

  function automatic logic [2:0] off_of(input logic [10:0] a, input logic [1:0] s);
    logic [2:0] o;
    o = 3'h0;
    unique case (s)
      emb_pkg::EMB_256X8: o = 3'h0;
      emb_pkg::EMB_512X4: o = {a[0], 2'b00};
      emb_pkg::EMB_1024X2: o = {a[1:0], 1'b0};
      emb_pkg::EMB_2048X1: o = a[2:0];
    endcase
    return o;
  endfunction

  function automatic logic [7:0] mask_of(input logic [1:0] s);
    logic [7:0] m;
    m = 8'hFF;
    unique case (s)
      emb_pkg::EMB_256X8: m = 8'hFF;
      emb_pkg::EMB_512X4: m = 8'h0F;
      emb_pkg::EMB_1024X2: m = 8'h03;
      emb_pkg::EMB_2048X1: m = 8'h01;
    endcase
    return m;
  endfunction

  // ==========================================================
  // state
  logic [7:0] ctrl_reg, ctrl_next;
  logic [15:0] div_reg, div_next;
  logic [7:0] ld_addr_reg, ld_addr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [10:0] addr_q_reg, addr_q_next;
  logic we_q_reg, we_q_next;
  logic sel_q_reg, sel_q_next;
  logic [7:0] din_q_reg, din_q_next;
  logic [11:0] wptr_reg, wptr_next;
  logic [11:0] rptr_reg, rptr_next;
  logic [2:0] rd_off_reg, rd_off_next;
  logic rd_sel_reg, rd_sel_next;
  logic [7:0] dout_reg, dout_next;
  logic full_reg, full_next;
  logic empty_reg, empty_next;

  logic in_ce;
  logic out_ce;
  emb_mem_if mif();

  // ==========================================================
  // input and output enables
  // one clock only: the two sides differ by enable rate, not by clock
  // RULE_06 separate side rates
  emb_cen_div #(.W(DIV_W)) u_in_div (
    .pclk(pclk),
    .presetn(presetn),
    .div(div_reg[DIV_W-1:0]),
    .ce(in_ce)
  );

  emb_cen_div #(.W(DIV_W)) u_out_div (
    .pclk(pclk),
    .presetn(presetn),
    .div(div_reg[emb_pkg::DIV_OUT_LSB +: DIV_W]),
    .ce(out_ce)
  );

  // RULE_01 full 2048-bit store
  emb_array u_array (
    .pclk(pclk),
    .mp(mif.mem)
  );

  // ==========================================================
  // decoded controls
  logic [1:0] mode;
  logic [1:0] shape;
  logic run;
  logic in_reg_on, out_reg_on, aw_reg_on;
  logic [10:0] addr_eff;
  logic we_eff, sel_eff;
  logic [7:0] din_eff;
  logic [11:0] depth, count;
  logic [10:0] rd_addr;
  logic push, pop, wr_pulse;
  logic setup, access;

  always_comb begin
    mode = ctrl_reg[emb_pkg::CTRL_MODE_LSB +: 2];
    shape = ctrl_reg[emb_pkg::CTRL_SHAPE_LSB +: 2];
    run = ctrl_reg[emb_pkg::CTRL_RUN_BIT];
    in_reg_on = ctrl_reg[emb_pkg::CTRL_INREG_BIT];
    out_reg_on = ctrl_reg[emb_pkg::CTRL_OUTREG_BIT];
    aw_reg_on = ctrl_reg[emb_pkg::CTRL_AWREG_BIT];
    // RULE_07 input register bypass
    addr_eff = aw_reg_on ? addr_q_reg : usr_addr;
    we_eff = aw_reg_on ? we_q_reg : usr_we;
    sel_eff = aw_reg_on ? sel_q_reg : usr_blk_sel;
    din_eff = in_reg_on ? din_q_reg : usr_din;
    // RULE_03 depth per shape
    depth = 12'(emb_pkg::ROWS) << shape;
    count = 12'(wptr_reg - rptr_reg);
    // RULE_05 internal write pulse
    // RULE_08 request qualified by block select
    wr_pulse = run && in_ce && we_eff && sel_eff &&
               (mode == emb_pkg::EMB_RAM || mode == emb_pkg::EMB_DPRAM);
    push = run && in_ce && we_eff && sel_eff && mode == emb_pkg::EMB_FIFO && !full_reg;
    pop = run && out_ce && usr_re && mode == emb_pkg::EMB_FIFO && !empty_reg;
    // RULE_02 read address source per mode
    unique case (mode)
      emb_pkg::EMB_DPRAM: rd_addr = usr_raddr;
      emb_pkg::EMB_FIFO: rd_addr = rptr_reg[10:0] & 11'(depth - 12'h001);
      default: rd_addr = addr_eff;
    endcase
    setup = psel && !penable && !pready_reg;
    access = psel && penable && pready_reg;
  end

  // ==========================================================
  // array port
  always_comb begin
    if (!run) begin
      // RULE_04 pattern preload while stopped
      mif.wr_en = access && pwrite && paddr == emb_pkg::OFS_LDDATA;
      mif.wr_row = ld_addr_reg;
      mif.wr_mask = 8'hFF;
      mif.wr_bits = pwdata[7:0];
      mif.rd_row_addr = ld_addr_reg;
    end else begin
      mif.wr_en = wr_pulse || push;
      mif.wr_row = push ? row_of(wptr_reg[10:0] & 11'(depth - 12'h001), shape)
                        : row_of(addr_eff, shape);
      mif.wr_mask = mask_of(shape) << (push ? off_of(wptr_reg[10:0], shape)
                                            : off_of(addr_eff, shape));
      mif.wr_bits = (din_eff & mask_of(shape)) << (push ? off_of(wptr_reg[10:0], shape)
                                                        : off_of(addr_eff, shape));
      mif.rd_row_addr = row_of(rd_addr, shape);
    end
  end

  // ==========================================================
  // datapath next state
  logic [7:0] word;

  always_comb begin
    addr_q_next = addr_q_reg;
    we_q_next = we_q_reg;
    sel_q_next = sel_q_reg;
    din_q_next = din_q_reg;
    if (in_ce) begin
      addr_q_next = usr_addr;
      we_q_next = usr_we;
      sel_q_next = usr_blk_sel;
      din_q_next = usr_din;
    end
    wptr_next = push ? 12'(wptr_reg + 12'h001) : wptr_reg;
    rptr_next = pop ? 12'(rptr_reg + 12'h001) : rptr_reg;
    if (!run) begin
      wptr_next = 12'h000;
      rptr_next = 12'h000;
    end
    full_next = 12'(wptr_next - rptr_next) == depth;
    empty_next = wptr_next == rptr_next;
    rd_off_next = off_of(rd_addr, shape);
    // RULE_11 deselected block reads zero in RAM and ROM modes so outputs can be ORed
    rd_sel_next = mode == emb_pkg::EMB_FIFO || mode == emb_pkg::EMB_DPRAM || sel_eff;
    // RULE_12 word width follows shape
    word = (mif.rd_row >> rd_off_reg) & mask_of(shape);
    if (!rd_sel_reg) begin
      word = 8'h00;
    end
    // RULE_07 output register bypass
    if (!run) begin
      dout_next = 8'h00;
    end else if (!out_reg_on || out_ce) begin
      dout_next = word;
    end else begin
      dout_next = dout_reg;
    end
  end

  // ==========================================================
  // apb registers
  always_comb begin
    ctrl_next = ctrl_reg;
    div_next = div_reg;
    ld_addr_next = ld_addr_reg;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    // answer one cycle after setup, no wait states
    pready_next = setup;
    if (setup) begin
      prdata_next = 32'h0000_0000;
      unique case (paddr)
        emb_pkg::OFS_CTRL: prdata_next = {24'h00_0000, ctrl_reg};
        emb_pkg::OFS_DIV: prdata_next = {16'h0000, div_reg};
        emb_pkg::OFS_LDADDR: prdata_next = {24'h00_0000, ld_addr_reg};
        emb_pkg::OFS_LDDATA: prdata_next = {24'h00_0000, mif.rd_row};
        emb_pkg::OFS_STATUS: prdata_next = {18'h0_0000, empty_reg, full_reg, count};
        default: pslverr_next = 1'b1;
      endcase
      if (pwrite) begin
        prdata_next = 32'h0000_0000;
      end
    end
    if (access && pwrite) begin
      unique case (paddr)
        // RULE_02 mode and shape chosen at setup
        emb_pkg::OFS_CTRL: ctrl_next = pwdata[7:0];
        emb_pkg::OFS_DIV: div_next = pwdata[15:0];
        emb_pkg::OFS_LDADDR: ld_addr_next = pwdata[7:0];
        emb_pkg::OFS_LDDATA: ld_addr_next = run ? ld_addr_reg : 8'(ld_addr_reg + 8'h01);
        default: ;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= emb_pkg::CTRL_RST;
      div_reg <= emb_pkg::DIV_RST;
      ld_addr_reg <= emb_pkg::LDADDR_RST;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      addr_q_reg <= 11'h000;
      we_q_reg <= 1'b0;
      sel_q_reg <= 1'b0;
      din_q_reg <= 8'h00;
      wptr_reg <= 12'h000;
      rptr_reg <= 12'h000;
      rd_off_reg <= 3'h0;
      rd_sel_reg <= 1'b0;
      dout_reg <= 8'h00;
      full_reg <= 1'b0;
      empty_reg <= 1'b1;
    end else begin
      ctrl_reg <= ctrl_next;
      div_reg <= div_next;
      ld_addr_reg <= ld_addr_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      addr_q_reg <= addr_q_next;
      we_q_reg <= we_q_next;
      sel_q_reg <= sel_q_next;
      din_q_reg <= din_q_next;
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      rd_off_reg <= rd_off_next;
      rd_sel_reg <= rd_sel_next;
      dout_reg <= dout_next;
      full_reg <= full_next;
      empty_reg <= empty_next;
    end
  end

  // ==========================================================
  // outputs
  // RULE_10 shared address lets blocks sit side by side
  assign usr_dout = dout_reg;
  assign usr_full = full_reg;
  assign usr_empty = empty_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

endmodule
`default_nettype wire

/* emb_embedded_memory_block_properties.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// port checker
module emb_embedded_memory_block_properties #(
  parameter int DIV_W = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // user side
  input wire logic [10:0] usr_addr,
  input wire logic [7:0] usr_din,
  input wire logic usr_we,
  input wire logic usr_blk_sel,
  input wire logic [7:0] usr_dout,
  input wire logic usr_full,
  input wire logic usr_empty
);
  // shadow of setup, so rules can be keyed to the mode in force
  logic [7:0] ctl_reg, ctl_next;
  logic [15:0] div_reg, div_next;
  logic wr_ok, plain;
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  assign plain = ctl_reg[7] && ctl_reg[6:4] == 3'h0 && div_reg == 16'h0000;
  always_comb begin
    ctl_next = ctl_reg;
    div_next = div_reg;
    if (wr_ok && paddr == emb_pkg::OFS_CTRL) ctl_next = pwdata[7:0];
    if (wr_ok && paddr == emb_pkg::OFS_DIV) div_next = pwdata[15:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_reg <= 8'h00;
      div_reg <= 16'h0000;
    end else begin
      ctl_reg <= ctl_next;
      div_reg <= div_next;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no pready");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready stuck");
  chk_err_decode: assert property (psel && !penable && paddr[1:0] == 2'b00 |=>
    pslverr == (paddr > emb_pkg::OFS_STATUS)) else $error("bad decode");
  chk_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error with data");
  chk_fifo_flags: assert property (!(usr_full && usr_empty))
    else $error("full and empty");
  chk_stop_empty: assert property (!ctl_reg[7] [*3] |-> usr_empty && !usr_full)
    else $error("stopped fifo not empty");
  chk_word_width: assert property (plain && ctl_reg == $past(ctl_reg, 3) |->
    (usr_dout >> (4'h8 >> ctl_reg[3:2])) == 8'h00) else $error("word too wide");
  chk_ram_readback: assert property (plain && ctl_reg[3:0] == 4'h0 && $past(usr_we, 3) &&
    !$past(usr_we, 2) && $past(usr_addr, 2) == $past(usr_addr, 3) && usr_blk_sel &&
    $past(usr_blk_sel, 3) && $past(usr_blk_sel, 2) && $past(usr_blk_sel) &&
    ctl_reg == $past(ctl_reg, 3) |-> usr_dout == $past(usr_din, 3))
    else $error("read back mismatch");
  chk_unsel_zero: assert property ((plain && !ctl_reg[1] && !usr_blk_sel) [*3] |->
    usr_dout == 8'h00) else $error("unselected block drives data");
  cover property (wr_ok && paddr == emb_pkg::OFS_CTRL && pwdata[1:0] == 2'b11);
  cover property (usr_full);
  cover property (pslverr);
endmodule
bind emb_embedded_memory_block emb_embedded_memory_block_properties #(.DIV_W(DIV_W)) chk_u (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .usr_addr(usr_addr), .usr_din(usr_din), .usr_we(usr_we), .usr_blk_sel(usr_blk_sel),
  .usr_dout(usr_dout), .usr_full(usr_full), .usr_empty(usr_empty));
`default_nettype wire

/* emb_user_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// fabric logic driving the block
module emb_user_model (
  // clock
  input wire logic pclk,
  // to block
  output logic [10:0] usr_addr,
  output logic [7:0] usr_din,
  output logic usr_we,
  output logic usr_blk_sel,
  output logic [10:0] usr_raddr,
  output logic usr_re,
  // from block
  input wire logic [7:0] usr_dout
);
  initial begin
    usr_addr = 11'h000;
    usr_din = 8'h00;
    usr_we = 1'b0;
    usr_blk_sel = 1'b1;
    usr_raddr = 11'h000;
    usr_re = 1'b0;
  end
  // request from fabric, top bit picks block
  task automatic put(input logic [11:0] a, input logic [7:0] d, input int hold);
    usr_addr <= a[10:0];
    usr_blk_sel <= !a[11];
    usr_din <= d;
    usr_we <= 1'b1;
    repeat (hold) @(posedge pclk);
    usr_we <= 1'b0;
    // stale data would hide a late capture
    usr_din <= ~d;
    @(posedge pclk);
  endtask
  task automatic get(input logic [11:0] a, input int n, output logic [7:0] q);
    usr_addr <= a[10:0];
    usr_raddr <= a[10:0];
    usr_blk_sel <= !a[11];
    repeat (n) @(posedge pclk);
    @(negedge pclk);
    q = usr_dout;
    @(posedge pclk);
  endtask
  task automatic pop();
    usr_re <= 1'b1;
    @(posedge pclk);
    usr_re <= 1'b0;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

/* emb_embedded_memory_block_test.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// bench top
module emb_embedded_memory_block_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr, usr_din, usr_dout, q8;
  logic [31:0] pwdata, prdata, q, rng, d;
  logic [10:0] usr_addr, usr_raddr;
  logic usr_we, usr_blk_sel, usr_re, usr_full, usr_empty;
  int failures, comparisons, a;
  bit mem [2048];
  logic [7:0] fq [$];
  emb_embedded_memory_block #(.DIV_W(8)) dut_u (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .usr_addr(usr_addr),
    .usr_din(usr_din), .usr_we(usr_we), .usr_blk_sel(usr_blk_sel), .usr_raddr(usr_raddr),
    .usr_re(usr_re), .usr_dout(usr_dout), .usr_full(usr_full), .usr_empty(usr_empty));
  emb_user_model user_u (.pclk(pclk), .usr_addr(usr_addr), .usr_din(usr_din),
    .usr_we(usr_we), .usr_blk_sel(usr_blk_sel), .usr_raddr(usr_raddr), .usr_re(usr_re),
    .usr_dout(usr_dout));
  task automatic finish_test();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      failures++;
      $display("ERROR %s exp %h got %h", nm, x, g);
    end
  endtask
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  // memory model: one linear bit space shared by all shapes
  function automatic logic [7:0] mr(input int ad, input int wd);
    mr = 8'h00;
    for (int i = 0; i < wd; i++) mr[i] = mem[ad * wd + i];
  endfunction
  task automatic mw(input int ad, input int wd, input logic [7:0] v);
    for (int i = 0; i < wd; i++) mem[ad * wd + i] = v[i];
  endtask
  function automatic logic [31:0] fstat();
    return 32'(fq.size()) | ((fq.size() == 256) ? 32'h00001000 : 32'h0);
  endfunction
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) begin
      failures++;
      finish_test();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic ram_chk(input int ad, input int wd, input int h, input int n);
    d = rnd() & ((32'h1 << wd) - 1);
    user_u.put(ad[11:0], d[7:0], h);
    mw(ad, wd, d[7:0]);
    user_u.get(ad[11:0], n, q8);
    cmp("ram word", {24'h0, mr(ad, wd)}, {24'h0, q8});
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    rng = 32'h00000E38;
    failures = 0;
    comparisons = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      if (i != 3) begin
        apb(1'b0, 8'(i * 4), 32'h0);
        cmp("reg reset", (i == 4) ? 32'h00002000 : 32'h0, q);
        cmp("slverr", (i == 5) ? 32'h1 : 32'h0, {31'h0, e});
      end
    end
    apb(1'b1, emb_pkg::OFS_CTRL, 32'h80);
    repeat (4) ram_chk(rnd() & 32'hFF, 8, 1, 2);
    a = rnd() & 32'hFF;
    ram_chk(a, 8, 1, 2);
    user_u.put(12'(a) | 12'h800, ~mr(a, 8), 1);
    user_u.get(12'(a) | 12'h800, 2, q8);
    cmp("unselected read", 32'h0, {24'h0, q8});
    user_u.get(12'(a), 2, q8);
    cmp("unselected write", {24'h0, mr(a, 8)}, {24'h0, q8});
    // fill every bit one at a time, then read as bytes
    apb(1'b1, emb_pkg::OFS_CTRL, 32'h8C);
    for (a = 0; a < 2048; a++) begin
      d = rnd();
      user_u.put(12'(a), d[7:0], 1);
      mw(a, 1, d[7:0]);
    end
    apb(1'b1, emb_pkg::OFS_CTRL, 32'h80);
    for (a = 0; a < 256; a++) begin
      user_u.get(12'(a), 2, q8);
      cmp("packed row", {24'h0, mr(a, 8)}, {24'h0, q8});
    end
    for (int s = 1; s < 3; s++) begin
      apb(1'b1, emb_pkg::OFS_CTRL, 32'h80 | (s << 2));
      ram_chk((256 << s) - 1, 8 >> s, 1, 2);
      repeat (8) ram_chk(rnd() % (256 << s), 8 >> s, 1, 2);
    end
    apb(1'b1, emb_pkg::OFS_DIV, 32'h0303);
    apb(1'b1, emb_pkg::OFS_CTRL, 32'hF0);
    repeat (6) ram_chk(rnd() & 32'hFF, 8, 4, 24);
    apb(1'b1, emb_pkg::OFS_DIV, 32'h0);
    apb(1'b1, emb_pkg::OFS_CTRL, 32'h0);
    apb(1'b1, emb_pkg::OFS_LDADDR, 32'h40);
    for (a = 64; a < 68; a++) begin
      d = rnd();
      apb(1'b1, emb_pkg::OFS_LDDATA, d);
      mw(a, 8, d[7:0]);
    end
    apb(1'b0, emb_pkg::OFS_LDADDR, 32'h0);
    cmp("load pointer", 32'h44, q);
    apb(1'b1, emb_pkg::OFS_CTRL, 32'h81);
    user_u.put(12'h040, ~mr(64, 8), 1);
    for (a = 64; a < 68; a++) begin
      user_u.get(12'(a), 2, q8);
      cmp("lookup", {24'h0, mr(a, 8)}, {24'h0, q8});
    end
    // dual port: read side ignores the block select
    apb(1'b1, emb_pkg::OFS_CTRL, 32'h82);
    a = rnd() & 32'hFF;
    ram_chk(a, 8, 1, 2);
    user_u.get(12'(a) | 12'h800, 2, q8);
    cmp("dual read", {24'h0, mr(a, 8)}, {24'h0, q8});
    // one push beyond full must be dropped
    apb(1'b1, emb_pkg::OFS_CTRL, 32'h83);
    repeat (257) begin
      d = rnd();
      user_u.put(12'h000, d[7:0], 1);
      if (fq.size() < 256) fq.push_back(d[7:0]);
    end
    apb(1'b0, emb_pkg::OFS_STATUS, 32'h0);
    cmp("fifo status", fstat(), q);
    cmp("full flag", 32'h1, {31'h0, usr_full});
    repeat (4) begin
      user_u.get(12'h000, 3, q8);
      cmp("fifo head", {24'h0, fq.pop_front()}, {24'h0, q8});
      user_u.pop();
    end
    apb(1'b0, emb_pkg::OFS_STATUS, 32'h0);
    cmp("fifo status", fstat(), q);
    cmp("empty flag", 32'h0, {31'h0, usr_empty});
    apb(1'b1, emb_pkg::OFS_CTRL, 32'h0);
    apb(1'b0, emb_pkg::OFS_STATUS, 32'h0);
    cmp("stopped status", 32'h00002000, q);
    cmp("empty flag", 32'h1, {31'h0, usr_empty});
    finish_test();
  end
endmodule
`default_nettype wire
